// File: shared/rcr_pkg.sv
// Purpose: shared constants for the regulator configuration register bank
// Assumes: 8-bit registers reached by decoded management-bus command codes
// Notes:   nonvolatile defaults and writable masks live here, one name each
package rcr_pkg;

  // data and command widths
  localparam int unsigned RCR_DW = 8;
  localparam int unsigned RCR_CW = 8;

  // command codes of the bank
  localparam logic [7:0] RCR_CMD_TRANSIENT = 8'hD9;
  localparam logic [7:0] RCR_CMD_MAX_CUR   = 8'hDA;
  localparam logic [7:0] RCR_CMD_BOOT      = 8'hDB;
  localparam logic [7:0] RCR_CMD_FREQ_SS   = 8'hDC;
  localparam logic [7:0] RCR_CMD_SLEW_MODE = 8'hDD;
  localparam logic [7:0] RCR_CMD_RAMP      = 8'hDE;

  // nonvolatile defaults
  localparam logic [7:0] RCR_NVM_TRANSIENT = 8'h77;
  localparam logic [7:0] RCR_NVM_MAX_CUR   = 8'h78;
  localparam logic [7:0] RCR_NVM_BOOT      = 8'h97;
  localparam logic [7:0] RCR_NVM_FREQ_SS   = 8'h20;
  localparam logic [7:0] RCR_NVM_SLEW_MODE = 8'h89;
  localparam logic [7:0] RCR_NVM_RAMP      = 8'h06;

  // writable bit masks, reserved bits cleared
  localparam logic [7:0] RCR_MASK_TRANSIENT = 8'h77;
  localparam logic [7:0] RCR_MASK_MAX_CUR   = 8'hFF;
  localparam logic [7:0] RCR_MASK_BOOT      = 8'hFF;
  localparam logic [7:0] RCR_MASK_FREQ_SS   = 8'hF3;
  localparam logic [7:0] RCR_MASK_SLEW_MODE = 8'hFF;
  localparam logic [7:0] RCR_MASK_RAMP      = 8'h07;

  // field positions
  localparam int unsigned RCR_UCT_LSB   = 4;
  localparam int unsigned RCR_OCT_LSB   = 0;
  localparam int unsigned RCR_FSW_LSB   = 4;
  localparam int unsigned RCR_SSD_LSB   = 0;
  localparam int unsigned RCR_VTS_BIT   = 7;
  localparam int unsigned RCR_PPS_BIT   = 6;
  localparam int unsigned RCR_PSE_BIT   = 4;
  localparam int unsigned RCR_FLL_BIT   = 3;
  localparam int unsigned RCR_SLEW_LSB  = 0;
  localparam int unsigned RCR_RAMP_LSB  = 0;

  // slew in 0.01 mV/us units, fast-slew adder
  localparam logic [9:0] RCR_FAST_SLEW_ADD = 10'h088;
  // trim step in mV per table
  localparam logic [3:0] RCR_TRIM_OLD_MV = 4'h5;
  localparam logic [3:0] RCR_TRIM_NEW_MV = 4'hA;

endpackage

// File: logic/rcr_cfg_reg.sv
// Purpose: one 8-bit configuration register with strap or stored default
// Assumes: load_default pulses once after reset release
// Notes:   reserved bits are masked on load and write, so they read zero
`timescale 1ns/1ps
module rcr_cfg_reg #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,          // system clock
  input  wire logic         reset_n,      // async reset, active low
  input  wire logic         load_default, // take default value
  input  wire logic [W-1:0] default_val,  // strap or stored default
  input  wire logic         wr_en,        // host write strobe
  input  wire logic [W-1:0] wr_data,      // host write data
  input  wire logic [W-1:0] mask,         // writable bits
  output logic      [W-1:0] q             // register contents
);

  logic [W-1:0] val_q;
  logic [W-1:0] val_d;

  // host write wins over the default load
  always_comb
  begin
    val_d = val_q;
    if (wr_en)
    begin
      val_d = wr_data & mask;
    end
    else if (load_default)
    begin
      val_d = default_val & mask;
    end
  end

  // storage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      val_q <= '0;
    end
    else
    begin
      val_q <= val_d;
    end
  end

  assign q = val_q;

endmodule

// File: logic/rcr_top.sv
// Purpose: configuration register bank of a multiphase buck controller
// Assumes: management-bus framing decoded upstream into command strobes
// Notes:   decoded settings are registered outputs, one cycle behind the bank
`timescale 1ns/1ps

// Functional notes
// - undershoot field 6:4 picks 20..140 mV; code 111 turns it off
// - overshoot field 2:0 picks 30..140 mV thresholds
// - full max-current byte is the operating current limit in amperes
// - boot byte is a VID code read through the selected table
// - frequency field 7:4 decodes 300..1000 kHz plus half-step codes
// - soft-start rate is slew divided by 1, 2, 4 or 8
// - written frequency/soft-start register overrides the freq/current strap
// - slew/mode bit 7 selects old (1) or new (0) VID table
// - bit 6 pairs phases 1/3 and 2/4 when set
// - bit 5 stores writes but steers nothing
// - bit 4 enables dynamic phase shedding
// - bit 3 selects a flat load line
// - slew field 2:0 picks 0.34..2.74 mV/us
// - written slew/mode register overrides the slew/mode strap
// - ramp field picks 20..120 mV in 20 mV steps, 110 gives 160, 111 gives 200
// - written ramp register overrides the ramp strap
// - slew/mode starts from strap, or 89h from stored defaults
// - boot register starts from strap, or 97h from stored defaults
// - trim step is 5 mV with old table, 10 mV with new
// - fast-slew option adds 1.36 mV/us to the selected slew
module rcr_top
  import rcr_pkg::*;
(
  input  wire logic                 CLK,               // 20 MHz clock
  input  wire logic                 RESET_N,           // async reset, active low
  input  wire logic                 NVM_DEFAULTS,      // 1: stored defaults, 0: straps
  input  wire logic [rcr_pkg::RCR_DW-1:0] STRAP_TRANSIENT, // strap-decoded thresholds
  input  wire logic [rcr_pkg::RCR_DW-1:0] STRAP_MAX_CUR,   // freq_current_strap_pin current
  input  wire logic [rcr_pkg::RCR_DW-1:0] STRAP_BOOT,      // boot strap code
  input  wire logic [rcr_pkg::RCR_DW-1:0] STRAP_FREQ_SS,   // freq_current_strap_pin freq/ss
  input  wire logic [rcr_pkg::RCR_DW-1:0] STRAP_SLEW_MODE, // slew/mode strap
  input  wire logic [rcr_pkg::RCR_DW-1:0] STRAP_RAMP,      // limit_sawtooth_strap_pin ramp
  input  wire logic                 FAST_SLEW_EN,      // fast-slew option level
  input  wire logic [rcr_pkg::RCR_CW-1:0] CMD_CODE,        // command code
  input  wire logic                 WR_STB,            // write request pulse
  input  wire logic [rcr_pkg::RCR_DW-1:0] WR_DATA,         // write byte
  input  wire logic                 RD_STB,            // read request pulse
  output logic      [rcr_pkg::RCR_DW-1:0] RD_DATA,         // read byte, registered
  output logic                      RD_VALID,          // read data valid pulse
  output logic                      CMD_NACK,          // unmapped code, combinational
  output logic      [7:0]           UNDERSHOOT_CUT_THRESHOLD, // mV
  output logic                      UNDERSHOOT_CUT_ENABLE,    // undershoot reduction on
  output logic      [7:0]           OVERSHOOT_CUT_THRESHOLD,  // mV
  output logic      [7:0]           MAX_LOAD_CURRENT,         // amperes
  output logic      [7:0]           STARTUP_VOLTAGE_CODE,     // VID code
  output logic      [9:0]           SWITCH_FREQUENCY_SEL,     // kHz
  output logic      [9:0]           SOFTSTART_RATE,           // 0.01 mV/us
  output logic      [1:0]           SOFTSTART_RATE_DIVIDER,   // log2 of divisor
  output logic                      VID_TABLE_SELECT,         // 1 old table
  output logic                      PHASE_PAIRING_SELECT,     // 1 paired phases
  output logic                      PHASE_SHED_ENABLE,        // shedding on
  output logic                      FLAT_LOADLINE_SELECT,     // zero load line
  output logic      [9:0]           OUTPUT_SLEW_RATE,         // 0.01 mV/us
  output logic      [7:0]           RAMP_HEIGHT,              // mV peak to peak
  output logic      [3:0]           TRIM_STEP                 // mV per trim lsb
);
  import rcr_pkg::*;

  localparam int unsigned NREG = 6;

  // register index order
  localparam logic [RCR_CW-1:0] CMD_TAB [NREG] = '{
    RCR_CMD_TRANSIENT, RCR_CMD_MAX_CUR, RCR_CMD_BOOT,
    RCR_CMD_FREQ_SS, RCR_CMD_SLEW_MODE, RCR_CMD_RAMP};
  localparam logic [RCR_DW-1:0] NVM_TAB [NREG] = '{
    RCR_NVM_TRANSIENT, RCR_NVM_MAX_CUR, RCR_NVM_BOOT,
    RCR_NVM_FREQ_SS, RCR_NVM_SLEW_MODE, RCR_NVM_RAMP};
  localparam logic [RCR_DW-1:0] MASK_TAB [NREG] = '{
    RCR_MASK_TRANSIENT, RCR_MASK_MAX_CUR, RCR_MASK_BOOT,
    RCR_MASK_FREQ_SS, RCR_MASK_SLEW_MODE, RCR_MASK_RAMP};

  logic [RCR_DW-1:0] strap_vec [NREG];
  logic [RCR_DW-1:0] reg_q     [NREG];
  logic [NREG-1:0]   hit;
  logic              loaded_q;
  logic              loaded_d;

  // strap values in register index order
  assign strap_vec[0] = STRAP_TRANSIENT;
  assign strap_vec[1] = STRAP_MAX_CUR;
  assign strap_vec[2] = STRAP_BOOT;
  assign strap_vec[3] = STRAP_FREQ_SS;
  assign strap_vec[4] = STRAP_SLEW_MODE;
  assign strap_vec[5] = STRAP_RAMP;

  // one-shot default load on the first edge after reset release
  always_comb
  begin
    loaded_d = 1'b1;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      loaded_q <= 1'b0;
    end
    else
    begin
      loaded_q <= loaded_d;
    end
  end

  // register bank; a host write overrides whatever default was loaded
  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    assign hit[i] = (CMD_CODE == CMD_TAB[i]);
    rcr_cfg_reg #(
      .W (RCR_DW)
    ) u_reg (
      .clk          (CLK),
      .reset_n      (RESET_N),
      .load_default (!loaded_q),
      .default_val  (NVM_DEFAULTS ? NVM_TAB[i] : strap_vec[i]),
      .wr_en        (WR_STB && hit[i]),
      .wr_data      (WR_DATA),
      .mask         (MASK_TAB[i]),
      .q            (reg_q[i])
    );
  end

  // unmapped command answered at once
  assign CMD_NACK = (WR_STB || RD_STB) && (hit == '0);

  // read path state
  logic [RCR_DW-1:0] rd_data_q;
  logic [RCR_DW-1:0] rd_data_d;
  logic              rd_valid_q;
  logic              rd_valid_d;

  // read mux; reads have no side effect on any register
  always_comb
  begin
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    if (RD_STB && (hit != '0))
    begin
      rd_valid_d = 1'b1;
      rd_data_d  = '0;
      for (int k = 0; k < NREG; k++)
      begin
        if (hit[k])
        begin
          rd_data_d = reg_q[k];
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign RD_DATA  = rd_data_q;
  assign RD_VALID = rd_valid_q;

  // field views
  logic [2:0] uct_f;
  logic [2:0] oct_f;
  logic [3:0] fsw_f;
  logic [1:0] ssd_f;
  logic [2:0] slew_f;
  logic [2:0] ramp_f;
  logic [7:0] smode;

  assign uct_f  = reg_q[0][RCR_UCT_LSB +: 3];
  assign oct_f  = reg_q[0][RCR_OCT_LSB +: 3];
  assign fsw_f  = reg_q[3][RCR_FSW_LSB +: 4];
  assign ssd_f  = reg_q[3][RCR_SSD_LSB +: 2];
  assign smode  = reg_q[4];
  assign slew_f = smode[RCR_SLEW_LSB +: 3];
  assign ramp_f = reg_q[5][RCR_RAMP_LSB +: 3];

  // decoded settings
  logic [7:0] uct_d,  uct_q;
  logic       uce_d,  uce_q;
  logic [7:0] oct_d,  oct_q;
  logic [9:0] fsw_d,  fsw_q;
  logic [9:0] slew_d, slew_q;
  logic [9:0] ssr_d,  ssr_q;
  logic [7:0] ramp_d, ramp_q;
  logic [3:0] trim_d, trim_q;

  // decode of the threshold, frequency, slew and ramp fields
  always_comb
  begin
    uce_d = 1'b1;
    unique case (uct_f)
      3'h0: uct_d = 8'h14;
      3'h1: uct_d = 8'h1E;
      3'h2: uct_d = 8'h3C;
      3'h3: uct_d = 8'h50;
      3'h4: uct_d = 8'h64;
      3'h5: uct_d = 8'h78;
      3'h6: uct_d = 8'h8C;
      3'h7:
      begin
        uct_d = 8'h00;
        uce_d = 1'b0;
      end
    endcase
    unique case (oct_f)
      3'h0: oct_d = 8'h1E;
      3'h1: oct_d = 8'h28;
      3'h2: oct_d = 8'h3C;
      3'h3: oct_d = 8'h50;
      3'h4: oct_d = 8'h64;
      3'h5: oct_d = 8'h78;
      3'h6: oct_d = 8'h8C;
      3'h7: oct_d = 8'h8C;
    endcase
    unique case (fsw_f)
      4'h0: fsw_d = 10'h12C;
      4'h1: fsw_d = 10'h190;
      4'h2: fsw_d = 10'h1F4;
      4'h3: fsw_d = 10'h258;
      4'h4: fsw_d = 10'h2BC;
      4'h5: fsw_d = 10'h320;
      4'h6: fsw_d = 10'h384;
      4'h7: fsw_d = 10'h3E8;
      4'h8: fsw_d = 10'h15E;
      4'h9: fsw_d = 10'h1C2;
      4'hA: fsw_d = 10'h226;
      4'hB: fsw_d = 10'h28A;
      4'hC: fsw_d = 10'h2EE;
      4'hD: fsw_d = 10'h352;
      4'hE: fsw_d = 10'h3B6;
      4'hF: fsw_d = 10'h3E8;
    endcase
    unique case (slew_f)
      3'h0: slew_d = 10'h022;
      3'h1: slew_d = 10'h044;
      3'h2: slew_d = 10'h066;
      3'h3: slew_d = 10'h088;
      3'h4: slew_d = 10'h0AA;
      3'h5: slew_d = 10'h0CC;
      3'h6: slew_d = 10'h0EE;
      3'h7: slew_d = 10'h112;
    endcase
    if (FAST_SLEW_EN)
    begin
      slew_d = slew_d + RCR_FAST_SLEW_ADD;
    end
    ssr_d = slew_d >> ssd_f;
    unique case (ramp_f)
      3'h0: ramp_d = 8'h14;
      3'h1: ramp_d = 8'h28;
      3'h2: ramp_d = 8'h3C;
      3'h3: ramp_d = 8'h50;
      3'h4: ramp_d = 8'h64;
      3'h5: ramp_d = 8'h78;
      3'h6: ramp_d = 8'hA0;
      3'h7: ramp_d = 8'hC8;
    endcase
    trim_d = smode[RCR_VTS_BIT] ? RCR_TRIM_OLD_MV : RCR_TRIM_NEW_MV;
  end

  // decoded settings registered for clean outputs
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      uct_q  <= '0;
      uce_q  <= 1'b0;
      oct_q  <= '0;
      fsw_q  <= '0;
      slew_q <= '0;
      ssr_q  <= '0;
      ramp_q <= '0;
      trim_q <= '0;
    end
    else
    begin
      uct_q  <= uct_d;
      uce_q  <= uce_d;
      oct_q  <= oct_d;
      fsw_q  <= fsw_d;
      slew_q <= slew_d;
      ssr_q  <= ssr_d;
      ramp_q <= ramp_d;
      trim_q <= trim_d;
    end
  end

  // mode bits, soft-start divider field and whole-byte settings straight from the bank
  assign MAX_LOAD_CURRENT       = reg_q[1];
  assign STARTUP_VOLTAGE_CODE   = reg_q[2];
  assign VID_TABLE_SELECT       = smode[RCR_VTS_BIT];
  assign PHASE_PAIRING_SELECT   = smode[RCR_PPS_BIT];
  assign PHASE_SHED_ENABLE      = smode[RCR_PSE_BIT];
  assign FLAT_LOADLINE_SELECT   = smode[RCR_FLL_BIT];
  assign SOFTSTART_RATE_DIVIDER = ssd_f;

  // decoded outputs
  assign UNDERSHOOT_CUT_THRESHOLD = uct_q;
  assign UNDERSHOOT_CUT_ENABLE    = uce_q;
  assign OVERSHOOT_CUT_THRESHOLD  = oct_q;
  assign SWITCH_FREQUENCY_SEL     = fsw_q;
  assign OUTPUT_SLEW_RATE         = slew_q;
  assign SOFTSTART_RATE           = ssr_q;
  assign RAMP_HEIGHT              = ramp_q;
  assign TRIM_STEP                = trim_q;

endmodule

// File: tb/rcr_top_monitor.sv
// Purpose: concurrent port checks for the configuration register bank
// Assumes: single clock, asynchronous active-low reset
// Notes:   bound to rcr_top from the bench top file
`timescale 1ns/1ps
module rcr_top_monitor (
  input wire logic       CLK,                    // clock
  input wire logic       RESET_N,                // reset, active low
  input wire logic [7:0] CMD_CODE,               // command code
  input wire logic       WR_STB,                 // write request
  input wire logic [7:0] WR_DATA,                // write byte
  input wire logic       RD_STB,                 // read request
  input wire logic [7:0] RD_DATA,                // read byte
  input wire logic       RD_VALID,               // read answer
  input wire logic       CMD_NACK,               // unmapped code
  input wire logic       UNDERSHOOT_CUT_ENABLE,  // undershoot cut on
  input wire logic [7:0] MAX_LOAD_CURRENT,       // amperes
  input wire logic [7:0] STARTUP_VOLTAGE_CODE,   // boot code
  input wire logic [9:0] SOFTSTART_RATE,         // soft-start rate
  input wire logic [1:0] SOFTSTART_RATE_DIVIDER, // divider code
  input wire logic       VID_TABLE_SELECT,       // table select
  input wire logic       PHASE_PAIRING_SELECT,   // phase pairing
  input wire logic       PHASE_SHED_ENABLE,      // shedding on
  input wire logic       FLAT_LOADLINE_SELECT,   // zero load line
  input wire logic [9:0] OUTPUT_SLEW_RATE,       // slew rate
  input wire logic [3:0] TRIM_STEP               // trim step
);
  logic [1:0] up_q; // edges since reset release, saturating
  logic [1:0] up_d; // next count
  // settle counter for decoded outputs
  always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N) up_q <= 2'h0;
    else up_q <= up_d;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  chk_maxcur_write: assert property (
    WR_STB && CMD_CODE == 8'hDA |=> MAX_LOAD_CURRENT == $past(WR_DATA))
    else $error("max current not taken from write");
  chk_boot_write: assert property (
    WR_STB && CMD_CODE == 8'hDB |=> STARTUP_VOLTAGE_CODE == $past(WR_DATA))
    else $error("boot code not taken from write");
  chk_undershoot_enable: assert property (
    WR_STB && CMD_CODE == 8'hD9 |=> ##1
      UNDERSHOOT_CUT_ENABLE == ($past(WR_DATA[6:4], 2) != 3'h7))
    else $error("undershoot enable wrong");
  chk_table_pairing: assert property (
    WR_STB && CMD_CODE == 8'hDD |=>
      {VID_TABLE_SELECT, PHASE_PAIRING_SELECT} == $past(WR_DATA[7:6]))
    else $error("table or pairing bit wrong");
  chk_shed_flat: assert property (
    WR_STB && CMD_CODE == 8'hDD |=>
      {PHASE_SHED_ENABLE, FLAT_LOADLINE_SELECT} == $past(WR_DATA[4:3]))
    else $error("shed or load line bit wrong");
  chk_trim_step: assert property (
    up_q == 2'h3 |-> TRIM_STEP == ($past(VID_TABLE_SELECT) ? 4'h5 : 4'hA))
    else $error("trim step does not follow table");
  chk_softstart_div: assert property (
    up_q == 2'h3 |->
      SOFTSTART_RATE == (OUTPUT_SLEW_RATE >> $past(SOFTSTART_RATE_DIVIDER)))
    else $error("soft-start rate not slew divided");
  chk_read_answer: assert property (
    up_q != 2'h0 |-> RD_VALID == $past(RD_STB && !CMD_NACK))
    else $error("read answer strobe wrong");
  chk_reserved_zero: assert property (
    RD_VALID |-> ($past(CMD_CODE) != 8'hDE || RD_DATA[7:3] == 5'h00)
      && ($past(CMD_CODE) != 8'hDC || RD_DATA[3:2] == 2'h0)
      && ($past(CMD_CODE) != 8'hD9 || {RD_DATA[7], RD_DATA[3]} == 2'h0))
    else $error("reserved bits read nonzero");
  chk_nack_hold: assert property (
    WR_STB && CMD_NACK |=> $stable(MAX_LOAD_CURRENT) && $stable(STARTUP_VOLTAGE_CODE))
    else $error("refused write changed a register");
  // main scenarios reached
  cover property (WR_STB && CMD_CODE == 8'hDD);
  cover property (RD_VALID);
  cover property (WR_STB && CMD_NACK);
endmodule

// File: tb/rcr_host_model.sv
// Purpose: management host issuing command strobes to the bank
// Assumes: requests launched and released on rising edges
// Notes:   released lines show inverted values; idle adds slow gaps
`timescale 1ns/1ps
module rcr_host_model (
  input  wire logic       clk,      // bank clock
  output logic      [7:0] cmd,      // command code
  output logic            wr_stb,   // write request
  output logic      [7:0] wr_data,  // write byte
  output logic            rd_stb,   // read request
  input  wire logic       rd_valid, // read answer strobe
  input  wire logic [7:0] rd_data,  // read byte
  input  wire logic       nack      // refusal flag
);
  logic nack_seen; // refusal seen on the last request
  int   idle;      // extra idle cycles before a request
  // quiet bus at time zero
  initial
  begin
    cmd = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
    idle = 0;
  end
  // single-byte write, taken at the edge after launch
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    cmd <= c;
    wr_data <= d;
    wr_stb <= 1'b1;
    #1 nack_seen = nack;
    @(posedge clk);
    wr_stb <= 1'b0;
    cmd <= ~c;
    wr_data <= ~d;
  endtask
  // single-byte read with bounded wait for the answer
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic ok);
    int i;
    repeat (idle) @(posedge clk);
    @(posedge clk);
    cmd <= c;
    rd_stb <= 1'b1;
    #1 nack_seen = nack;
    @(posedge clk);
    rd_stb <= 1'b0;
    cmd <= ~c;
    ok = 1'b0;
    d = 8'h00;
    for (i = 0; i < 3 && !ok; i++)
    begin
      #1 ok = rd_valid;
      d = rd_data;
      if (!ok) @(posedge clk);
    end
  endtask
endmodule

// File: tb/rcr_top_tb_top.sv
// Purpose: self-checking bench for the configuration register bank
// Assumes: 20 MHz clock, host model drives the command strobes
// Notes:   expectations come from the field tables below
`timescale 1ns/1ps
module rcr_top_tb_top;
  logic       clk, reset_n, nvm, fast, wr_stb, rd_stb, rd_valid, nack, uc_en;
  logic       vid, pair, shed, flat, rok;
  logic [7:0] cmd, wr_data, rd_data, uc_thr, oc_thr, mcur, boot, ramp, rdv, b;
  logic [9:0] switch_frequency_sel, ss_rate, slew;
  logic [1:0] ss_div;
  logic [3:0] trim;
  logic [7:0] strap [6];
  int         n_mismatch = 0;
  int         check_count = 0;
  localparam logic [7:0] CODE [6] = '{8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE};
  localparam logic [7:0] NVMV [6] = '{8'h77, 8'h78, 8'h97, 8'h20, 8'h89, 8'h06};
  localparam logic [7:0] WMSK [6] = '{8'h77, 8'hFF, 8'hFF, 8'hF3, 8'hFF, 8'h07};
  localparam logic [7:0] UC_T [7] = '{8'h14, 8'h1E, 8'h3C, 8'h50, 8'h64, 8'h78, 8'h8C};
  localparam logic [7:0] OC_T [8] = '{8'h1E, 8'h28, 8'h3C, 8'h50, 8'h64, 8'h78, 8'h8C, 8'h8C};
  localparam logic [7:0] RAMP_T [8] = '{8'h14, 8'h28, 8'h3C, 8'h50, 8'h64, 8'h78, 8'hA0, 8'hC8};
  localparam logic [9:0] SLEW_T [8] = '{10'h022, 10'h044, 10'h066, 10'h088,
                                        10'h0AA, 10'h0CC, 10'h0EE, 10'h112};
  localparam logic [9:0] FSW_T [16] = '{10'h12C, 10'h190, 10'h1F4, 10'h258, 10'h2BC,
    10'h320, 10'h384, 10'h3E8, 10'h15E, 10'h1C2, 10'h226, 10'h28A, 10'h2EE, 10'h352,
    10'h3B6, 10'h3E8};
  // clock, 50 ns period
  initial clk = 1'b0;
  always #25 clk = ~clk;
  rcr_host_model host (.clk(clk), .cmd(cmd), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb), .rd_valid(rd_valid), .rd_data(rd_data), .nack(nack));
  rcr_top dut (.CLK(clk), .RESET_N(reset_n), .NVM_DEFAULTS(nvm),
    .STRAP_TRANSIENT(strap[0]), .STRAP_MAX_CUR(strap[1]), .STRAP_BOOT(strap[2]),
    .STRAP_FREQ_SS(strap[3]), .STRAP_SLEW_MODE(strap[4]), .STRAP_RAMP(strap[5]),
    .FAST_SLEW_EN(fast), .CMD_CODE(cmd), .WR_STB(wr_stb), .WR_DATA(wr_data),
    .RD_STB(rd_stb), .RD_DATA(rd_data), .RD_VALID(rd_valid), .CMD_NACK(nack),
    .UNDERSHOOT_CUT_THRESHOLD(uc_thr), .UNDERSHOOT_CUT_ENABLE(uc_en),
    .OVERSHOOT_CUT_THRESHOLD(oc_thr), .MAX_LOAD_CURRENT(mcur),
    .STARTUP_VOLTAGE_CODE(boot), .SWITCH_FREQUENCY_SEL(switch_frequency_sel), .SOFTSTART_RATE(ss_rate),
    .SOFTSTART_RATE_DIVIDER(ss_div), .VID_TABLE_SELECT(vid),
    .PHASE_PAIRING_SELECT(pair), .PHASE_SHED_ENABLE(shed),
    .FLAT_LOADLINE_SELECT(flat), .OUTPUT_SLEW_RATE(slew), .RAMP_HEIGHT(ramp),
    .TRIM_STEP(trim));
  // verdict and end of run
  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // value comparison
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // read one register and compare; a missing answer ends the run
  task automatic rdc(input logic [7:0] c, input logic [7:0] e);
    host.rd(c, rdv, rok);
    cmp({9'h000, rok}, 10'h001);
    cmp({2'h0, rdv}, {2'h0, e});
    if (rok !== 1'b1) tally_and_finish();
  endtask
  // write, then let the decoded outputs settle
  task automatic w(input logic [7:0] c, input logic [7:0] d);
    host.wr(c, d);
    @(posedge clk);
    #1;
  endtask
  // reset held for 4 cycles with the chosen default source
  task automatic do_reset(input logic n);
    @(posedge clk);
    reset_n <= 1'b0;
    nvm <= n;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    nvm = 1'b1;
    fast = 1'b0;
    strap = '{8'hF8, 8'h3C, 8'h55, 8'hFD, 8'h2E, 8'hFB};
    do_reset(1'b1);
    for (int i = 0; i < 6; i++)
    begin
      rdc(CODE[i], NVMV[i]);
      w(CODE[i], 8'hFF);
      rdc(CODE[i], WMSK[i]);
    end
    host.wr(8'hDF, 8'h00);
    cmp({9'h000, host.nack_seen}, 10'h001);
    host.rd(8'hE0, rdv, rok);
    cmp({8'h00, rok, host.nack_seen}, 10'h001);
    rdc(8'hDA, 8'hFF);
    for (int i = 0; i < 8; i++)
    begin
      w(8'hD9, {1'b1, i[2:0], 1'b1, 3'(7 - i)});
      cmp({9'h000, uc_en}, {9'h000, i != 7});
      if (i < 7) cmp({2'h0, uc_thr}, {2'h0, UC_T[i]});
      cmp({2'h0, oc_thr}, {2'h0, OC_T[7 - i]});
    end
    w(8'hDA, 8'hA5);
    cmp({2'h0, mcur}, 10'h0A5);
    w(8'hDB, 8'h5A);
    cmp({2'h0, boot}, 10'h05A);
    host.idle = 2;
    for (int i = 0; i < 16; i++)
    begin
      w(8'hDC, {i[3:0], 2'h3, i[1:0]});
      cmp(switch_frequency_sel, FSW_T[i]);
      cmp({8'h00, ss_div}, {8'h00, i[1:0]});
      cmp(ss_rate, SLEW_T[7] >> i[1:0]);
    end
    host.idle = 0;
    for (int i = 0; i < 16; i++)
    begin
      b = {i[0], i[1], i[2], ~i[0], ~i[2], i[2:0]};
      @(posedge clk);
      fast <= i[3];
      w(8'hDD, b);
      cmp({6'h00, vid, pair, shed, flat}, {6'h00, b[7:6], b[4:3]});
      cmp({6'h00, trim}, b[7] ? 10'h005 : 10'h00A);
      cmp(slew, SLEW_T[b[2:0]] + (i[3] ? 10'h088 : 10'h000));
    end
    for (int i = 0; i < 8; i++)
    begin
      w(8'hDE, {5'h1F, i[2:0]});
      cmp({2'h0, ramp}, {2'h0, RAMP_T[i]});
    end
    do_reset(1'b0);
    for (int i = 0; i < 6; i++)
      rdc(CODE[i], strap[i] & WMSK[i]);
    for (int i = 3; i < 6; i++)
    begin
      w(CODE[i], 8'h41);
      rdc(CODE[i], 8'h41 & WMSK[i]);
    end
    tally_and_finish();
  end
endmodule
bind rcr_top rcr_top_monitor mon (.CLK(CLK), .RESET_N(RESET_N), .CMD_CODE(CMD_CODE),
  .WR_STB(WR_STB), .WR_DATA(WR_DATA), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .CMD_NACK(CMD_NACK), .UNDERSHOOT_CUT_ENABLE(UNDERSHOOT_CUT_ENABLE),
  .MAX_LOAD_CURRENT(MAX_LOAD_CURRENT), .STARTUP_VOLTAGE_CODE(STARTUP_VOLTAGE_CODE),
  .SOFTSTART_RATE(SOFTSTART_RATE), .SOFTSTART_RATE_DIVIDER(SOFTSTART_RATE_DIVIDER),
  .VID_TABLE_SELECT(VID_TABLE_SELECT), .PHASE_PAIRING_SELECT(PHASE_PAIRING_SELECT),
  .PHASE_SHED_ENABLE(PHASE_SHED_ENABLE), .FLAT_LOADLINE_SELECT(FLAT_LOADLINE_SELECT),
  .OUTPUT_SLEW_RATE(OUTPUT_SLEW_RATE), .TRIM_STEP(TRIM_STEP));
